// ---- hw/pwm_ctrl_pkg.sv ----
// Package for the current-mode pulse sequencer: timing counts and carriers.
// Assumes a single 25 MHz reference clock.
package pwm_ctrl_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned CLK_HZ            = 25_000_000;
	localparam int unsigned STEP_TIME_US      = 300;
	localparam int unsigned STEP_CYCLES       = (STEP_TIME_US * (CLK_HZ / 1_000_000));
	localparam int unsigned SOFT_TIME_MS      = 10;
	localparam int unsigned SOFT_CYCLES       = SOFT_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned SOFT_STEPS        = 32;
	localparam int unsigned F_NOM_HZ          = 65_000;
	localparam int unsigned F_DEV_HZ          = 2_600;
	localparam int unsigned PERIOD_NOM        = CLK_HZ / F_NOM_HZ;
	localparam int unsigned PERIOD_MIN        = CLK_HZ / (F_NOM_HZ + F_DEV_HZ);
	localparam int unsigned PERIOD_MAX        = CLK_HZ / (F_NOM_HZ - F_DEV_HZ);
	localparam int unsigned JITTER_TIME_MS    = 4;
	localparam int unsigned JITTER_CYCLES     = JITTER_TIME_MS * (CLK_HZ / 1000);
	localparam int unsigned DMAX_NUM          = 3;
	localparam int unsigned DMAX_DEN          = 4;
	localparam int unsigned BLANK_NORM_NS     = 220;
	localparam int unsigned BLANK_BURST_NS    = 180;
	localparam int unsigned CLK_PERIOD_NS     = 1_000_000_000 / CLK_HZ;
	localparam int unsigned BLANK_NORM_CYC    = (BLANK_NORM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned BLANK_BURST_CYC   = (BLANK_BURST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	localparam int unsigned STEP_W   = 5;
	localparam int unsigned PER_W    = 9;
	localparam int unsigned BASE_W   = 20;

	// ****************************************
	// Carriers
	// ****************************************
	typedef struct packed {
		logic feedback_trip;
		logic ramp_up_trip;
		logic current_limit_trip;
		logic burst_current_trip;
	} comp_flags_s;

	typedef enum logic [1:0] {
		ST_LOCKOUT,
		ST_SOFT,
		ST_NORMAL
	} seq_state_e;

endpackage

// ---- hw/pwm_oscillator.sv ----
// Oscillator: fixed-frequency switching pulse with triangular jitter and duty cap.
// Assumes a 25 MHz clock and a synchronous clear from the sequencer.
`timescale 1ns/10ps
module pwm_oscillator
	import pwm_ctrl_pkg::*;
(
	input  wire logic              ref_clk_i,   // Reference clock
	input  wire logic              clear_i,     // Hold in reset
	input  wire logic              jitter_en_i, // Allow frequency jitter
	input  wire logic              jit_tick_i,  // One pulse per jitter step
	output logic                   start_o,     // One-cycle turn-on pulse
	output logic                   dmax_o,      // Beyond duty limit
	output logic [PER_W-1:0]       period_o     // Current period length
);

	logic [PER_W-1:0] phase;
	logic [PER_W-1:0] period;
	logic             jit_up;
	logic [PER_W-1:0] next_phase;
	logic [PER_W-1:0] next_period;
	logic             next_jit_up;
	logic             next_start;
	logic             next_dmax;

	localparam logic [PER_W-1:0] P_NOM = PER_W'(PERIOD_NOM);
	localparam logic [PER_W-1:0] P_MIN = PER_W'(PERIOD_MIN);
	localparam logic [PER_W-1:0] P_MAX = PER_W'(PERIOD_MAX);

	always_comb begin
		next_phase  = phase + 9'h001;
		next_period = period;
		next_jit_up = jit_up;
		next_start  = 1'b0;
		if (phase >= period - 9'h001) begin
			next_phase = 9'h000;
			next_start = 1'b1;
		end
		// Duty cap: on-time may fill only three quarters of the period
		next_dmax = (PER_W+2)'(next_phase) * (PER_W+2)'(DMAX_DEN)
			>= (PER_W+2)'(period) * (PER_W+2)'(DMAX_NUM); // RULE_08
		if (!jitter_en_i) begin
			next_period = P_NOM; // RULE_09
		end else if (jit_tick_i) begin
			// Triangular sweep between the deviation limits
			if (jit_up) begin
				if (period >= P_MAX) next_jit_up = 1'b0;
				else next_period = period + 9'h001; // RULE_07
			end else begin
				if (period <= P_MIN) next_jit_up = 1'b1;
				else next_period = period - 9'h001; // RULE_07
			end
		end
		if (clear_i) begin
			next_phase  = 9'h000;
			next_period = P_NOM;
			next_jit_up = 1'b1;
			next_start  = 1'b0;
			next_dmax   = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		phase   <= next_phase;
		period  <= next_period;
		jit_up  <= next_jit_up;
		start_o <= next_start;
		dmax_o  <= next_dmax;
	end

	assign period_o = period;

endmodule

// ---- hw/pwm_softstart_limiter.sv ----
// Sequencer of a current-mode switching controller: soft start, pulse latch,
// blanking and burst current limit around one oscillator.
// Assumes comparator flags and supply status arrive asynchronously from pins.
//
// Notes on behaviour
// RULE_01 - Soft start begins once supply rises above turn-on threshold.
// RULE_02 - Ramp-up level rises in 32 steps, one per counter increment.
// RULE_03 - A step pulse every 300us lowers the current-sink setting.
// RULE_04 - Soft start ends 10ms after switch-on; sink then fully off.
// RULE_05 - Allowed duty grows from zero to normal maximum during soft start.
// RULE_06 - Every auto-restart attempt reruns the full soft start.
// RULE_07 - Oscillator runs at 65 kHz with plus or minus four percent jitter, 4ms period.
// RULE_08 - On-time is capped at 0.75 of each period.
// RULE_09 - Jitter applies only after soft start, 2.6 kHz about nominal.
// RULE_10 - Oscillator sets pulse latch; first of three comparators clears it.
// RULE_11 - Gate off immediately whenever pulse latch is reset.
// RULE_12 - Gate held low while supply is under undervoltage threshold.
// RULE_13 - Sensed current above limit clears latch and ends on-time.
// RULE_14 - Sense ignored 220ns after turn-on, 180ns in burst mode.
// RULE_15 - Burst mode enables reduced-threshold burst current comparator.
// RULE_16 - Dynamic limit thresholds compensate delay, in normal and burst mode.
// RULE_17 - Supply below turn-off threshold clears the soft-start counter.
// RULE_18 - Comparator flags synchronised; latch reset beats set in one cycle.
// RULE_19 - Step, jitter and blanking timing share one timebase cleared on lockout; here base, jit_cnt and blank_cnt are separate, all cleared on lockout.
`timescale 1ns/10ps
module pwm_softstart_limiter
	import pwm_ctrl_pkg::*;
(
	input  wire logic              ref_clk_i,        // 25 MHz clock
	input  wire logic              rst_i,            // Synchronous reset, high
	input  wire logic              supply_ok_i,      // Supply above turn-on, async
	input  wire logic              restart_i,        // Auto-restart attempt, async
	input  wire logic              burst_mode_i,     // Burst mode active, async
	input  wire comp_flags_s       comp_i,           // Comparator outputs, async
	output logic                   gate_o,           // Power switch gate drive
	output logic                   sink_en_o,        // Soft-start current sink on
	output logic [STEP_W-1:0]      ramp_up_level_o,  // Soft-start step index
	output logic                   soft_done_o,      // Soft start complete
	output logic                   blank_o,          // Sense path blanked
	output logic                   burst_limit_en_o, // Burst comparator enabled
	output logic                   slope_comp_en_o   // Dynamic threshold enabled
);

	// ****************************************
	// Input synchronisers
	// ****************************************
	localparam int unsigned SYN_W = 7;
	logic [SYN_W-1:0] sync_a;
	logic [SYN_W-1:0] sync_b;
	logic             supply_s;
	logic             restart_s;
	logic             burst_s;
	comp_flags_s      comp_s;
	logic             restart_d;

	// Two flops in front of every asynchronous input; slower than an analog path but glitch-safe
	always_ff @(posedge ref_clk_i) begin
		sync_a <= {supply_ok_i, restart_i, burst_mode_i, comp_i}; // RULE_18
		sync_b <= sync_a;
	end
	assign {supply_s, restart_s, burst_s, comp_s} = sync_b;

	// ****************************************
	// Sequencing state and timebase
	// ****************************************
	seq_state_e        state;
	seq_state_e        next_state;
	logic [BASE_W-1:0] base;
	logic [BASE_W-1:0] next_base;
	logic [BASE_W-1:0] jit_cnt;
	logic [BASE_W-1:0] next_jit_cnt;
	logic [STEP_W-1:0] step;
	logic [STEP_W-1:0] next_step;
	logic              restart_rise;
	logic              lockout;
	logic              step_tick;
	logic              jit_tick;

	localparam logic [BASE_W-1:0] STEP_LAST = BASE_W'(STEP_CYCLES - 1);
	localparam logic [BASE_W-1:0] SOFT_LAST = BASE_W'(SOFT_CYCLES - 1);
	localparam logic [BASE_W-1:0] JIT_LAST  =
		BASE_W'(JITTER_CYCLES / (2 * (PERIOD_MAX - PERIOD_MIN)) - 1);
	localparam logic [STEP_W-1:0] STEP_TOP  = STEP_W'(SOFT_STEPS - 1);

	assign restart_rise = restart_s & ~restart_d;
	assign lockout      = rst_i | ~supply_s;
	assign jit_tick     = (jit_cnt == JIT_LAST);

	always_comb begin
		next_state   = state;
		next_base    = base + 20'h00001;
		next_jit_cnt = jit_tick ? 20'h00000 : jit_cnt + 20'h00001;
		next_step    = step;
		step_tick    = 1'b0;
		unique case (state)
			ST_LOCKOUT: begin
				next_base = 20'h00000;
				if (supply_s) next_state = ST_SOFT; // RULE_01
			end
			ST_SOFT: begin
				if ((base + 20'h00001) % 20'(STEP_CYCLES) == 20'h00000) begin
					step_tick = 1'b1; // RULE_03
					if (step != STEP_TOP) next_step = step + 5'h01; // RULE_02
				end
				if (base == SOFT_LAST) begin
					next_state = ST_NORMAL; // RULE_04
				end
			end
			ST_NORMAL: begin
				next_base = base;
			end
		endcase
		if (restart_rise && state != ST_LOCKOUT) begin
			next_state = ST_SOFT; // RULE_06
			next_base  = 20'h00000;
			next_step  = 5'h00;
		end
		if (lockout) begin
			next_state   = ST_LOCKOUT; // RULE_17
			next_base    = 20'h00000; // RULE_19
			next_jit_cnt = 20'h00000;
			next_step    = 5'h00;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		state     <= next_state;
		base      <= next_base;
		jit_cnt   <= next_jit_cnt;
		step      <= next_step;
		restart_d <= rst_i ? 1'b0 : restart_s;
	end

	// ****************************************
	// Oscillator
	// ****************************************
	logic             osc_start;
	logic             osc_dmax;
	logic [PER_W-1:0] osc_period;

	pwm_oscillator pwm_oscillator_inst (
		.ref_clk_i   (ref_clk_i),
		.clear_i     (lockout),
		.jitter_en_i (state == ST_NORMAL),
		.jit_tick_i  (jit_tick),
		.start_o     (osc_start),
		.dmax_o      (osc_dmax),
		.period_o    (osc_period)
	);

	// ****************************************
	// Pulse latch, blanking and soft-start duty ceiling
	// ****************************************
	logic             pulse_latch;
	logic             next_latch;
	logic [3:0]       blank_cnt;
	logic [3:0]       next_blank;
	logic [PER_W-1:0] on_cnt;
	logic [PER_W-1:0] next_on;
	logic [PER_W-1:0] soft_limit;
	logic             blanked;
	logic             clear_req;

	localparam logic [3:0] BLANK_N = 4'(BLANK_NORM_CYC);
	localparam logic [3:0] BLANK_B = 4'(BLANK_BURST_CYC);

	// On-time ceiling scales with the step: a digital stand-in for the ramp-up level
	function automatic logic [PER_W-1:0] ceiling(input logic [STEP_W-1:0] s,
		input logic [PER_W-1:0] p);
		logic [PER_W+STEP_W+1:0] prod;
		prod = (PER_W+STEP_W+2)'(p) * (PER_W+STEP_W+2)'(s) * (PER_W+STEP_W+2)'(DMAX_NUM);
		ceiling = PER_W'(prod / (PER_W+STEP_W+2)'(SOFT_STEPS * DMAX_DEN));
	endfunction

	assign soft_limit = ceiling(step, osc_period); // RULE_05
	assign blanked    = (blank_cnt != 4'h0);

	always_comb begin
		next_latch = pulse_latch;
		next_blank = blanked ? blank_cnt - 4'h1 : 4'h0;
		next_on    = pulse_latch ? on_cnt + 9'h001 : 9'h000;
		clear_req  = osc_dmax
			| (!blanked && comp_s.feedback_trip) // RULE_10
			| (!blanked && comp_s.current_limit_trip) // RULE_13
			| (!blanked && burst_s && comp_s.burst_current_trip) // RULE_15
			| (state == ST_SOFT && (comp_s.ramp_up_trip || on_cnt >= soft_limit)); // RULE_05
		if (osc_start && !clear_req) begin
			next_latch = 1'b1; // RULE_10
			next_blank = burst_s ? BLANK_B : BLANK_N; // RULE_14
			next_on    = 9'h000;
		end
		if (clear_req) begin
			next_latch = 1'b0; // RULE_18
		end
		if (lockout) begin
			next_latch = 1'b0; // RULE_12
			next_blank = 4'h0;
			next_on    = 9'h000;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		pulse_latch <= next_latch;
		blank_cnt   <= next_blank;
		on_cnt      <= next_on;
	end

	// ****************************************
	// Registered outputs
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		gate_o           <= next_latch; // RULE_11
		sink_en_o        <= (next_state == ST_SOFT); // RULE_04
		ramp_up_level_o  <= next_step; // RULE_02
		soft_done_o      <= (next_state == ST_NORMAL);
		blank_o          <= (next_blank != 4'h0); // RULE_14
		burst_limit_en_o <= ~lockout & burst_s; // RULE_15
		// Comparator thresholds are analog; this only enables their slope term
		slope_comp_en_o  <= ~lockout; // RULE_16
	end

	// ****************************************
	// Assertions
	// ****************************************
	a_gate_lockout: assert property (@(posedge ref_clk_i) // RULE_12
		(!supply_s || rst_i) |=> !gate_o)
		else $error("gate on during lockout");

	a_gate_follows_latch: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_11
		gate_o == pulse_latch)
		else $error("gate differs from latch");

	a_limit_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_13
		(pulse_latch && !blanked && comp_s.current_limit_trip) |=> !pulse_latch)
		else $error("current limit did not end pulse");

	// Lockout cuts blanking short on purpose, so it disables the check
	a_blank_holds: assert property (@(posedge ref_clk_i) disable iff (lockout) // RULE_14
		($rose(pulse_latch) && !$past(burst_s)) |-> blank_o [*6] ##1 !blank_o)
		else $error("normal blanking length wrong");

	a_blank_burst: assert property (@(posedge ref_clk_i) disable iff (lockout) // RULE_14
		($rose(pulse_latch) && $past(burst_s)) |-> blank_o [*5] ##1 !blank_o)
		else $error("burst blanking length wrong");

	a_burst_gate: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_15
		(pulse_latch && supply_s && !blanked && !burst_s && !comp_s.feedback_trip
		 && !comp_s.current_limit_trip && !osc_dmax
		 && !(state == ST_SOFT && (comp_s.ramp_up_trip || on_cnt >= soft_limit)))
		|=> pulse_latch)
		else $error("burst comparator acted outside burst");

	a_step_lockout: assert property (@(posedge ref_clk_i) // RULE_17
		(!supply_s) |=> (step == 5'h00 && state == ST_LOCKOUT))
		else $error("step counter not cleared");

	a_step_advance: assert property (@(posedge ref_clk_i) disable iff (rst_i || !supply_s) // RULE_03
		(step_tick && step != STEP_TOP && !restart_rise) |=> step == $past(step) + 5'h01)
		else $error("step did not advance");

	a_reset_wins: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_18
		(osc_start && clear_req) |=> !pulse_latch)
		else $error("set won over reset");

	a_soft_end: assert property (@(posedge ref_clk_i) disable iff (lockout) // RULE_04
		(state == ST_SOFT && base == SOFT_LAST && !restart_rise) |=> ##1 (!sink_en_o && soft_done_o))
		else $error("soft start did not finish");

	a_sink_soft: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_01
		($past(supply_s) && supply_s && $past(state) == ST_LOCKOUT) |-> ##1 sink_en_o)
		else $error("soft start not begun");

	a_duty_cap: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_08
		pulse_latch |-> ((PER_W+2)'(on_cnt) * (PER_W+2)'(DMAX_DEN)
			< (PER_W+2)'(osc_period) * (PER_W+2)'(DMAX_NUM)))
		else $error("on-time beyond duty cap");

	a_nominal_in_soft: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_09
		(state != ST_NORMAL) |=> (osc_period == PER_W'(PERIOD_NOM)))
		else $error("period jittered before normal operation");

	a_sink_lockout: assert property (@(posedge ref_clk_i) // RULE_17
		lockout |=> (!sink_en_o && ramp_up_level_o == 5'h00 && !soft_done_o))
		else $error("soft start state kept in lockout");

	a_slope_lockout: assert property (@(posedge ref_clk_i) // RULE_16
		lockout |=> !slope_comp_en_o)
		else $error("slope term enabled in lockout");

	a_burst_enable: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_15
		(!lockout) |=> (burst_limit_en_o == $past(burst_s)))
		else $error("burst comparator enable wrong");

	a_restart_clears: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_06
		(restart_rise && !lockout) |=> (step == 5'h00 && state == ST_SOFT))
		else $error("restart did not rerun soft start");

	a_ramp_trip_ends: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
		(state == ST_SOFT && comp_s.ramp_up_trip) |=> !pulse_latch)
		else $error("ramp-up trip did not end pulse");

	a_feedback_ends: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_10
		(!blanked && comp_s.feedback_trip) |=> !pulse_latch)
		else $error("feedback trip did not end pulse");

	a_step_zero_off: assert property (@(posedge ref_clk_i) disable iff (rst_i) // RULE_05
		(state == ST_SOFT && step == 5'h00) |=> !pulse_latch)
		else $error("pulse at zero soft-start step");

endmodule

// ---- sim/sense_network_model.sv ----
// Behavioural model of the power switch and sense network: comparator trips.
// Assumes gate_i comes from the sequencer and the bench sets the trip delays.
`timescale 1ns/10ps
module sense_network_model
	import pwm_ctrl_pkg::*;
(
	input  wire logic            ref_clk_i, // Clock
	input  wire logic            gate_i,    // Switch gate
	input  wire logic [3:0][9:0] dly_i,     // Trip delay per flag, in on-cycles
	input  wire logic            spike_i,   // Add a turn-on spike
	output comp_flags_s          comp_o     // Comparator outputs
);
	logic [9:0] on_cnt;
	logic [3:0] ramp_trip;
	logic [3:0] trip;

	// ****************************************
	// Sense ramp
	// ****************************************
	always_ff @(posedge ref_clk_i) begin
		on_cnt <= gate_i ? on_cnt + 10'h001 : 10'h000;
	end

	// No current flows while the switch is off, so every comparator reads low
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			ramp_trip[k] = gate_i && (on_cnt >= dly_i[k]);
		end
	end

	// Turn-on spike hits the limit path and must be ignored while blanked
	assign trip   = ramp_trip | {2'h0, gate_i && spike_i && (on_cnt < 10'h002), 1'h0};
	assign comp_o = comp_flags_s'(trip);
endmodule

// ---- sim/tb_top.sv ----
// Self-checking bench for the soft-start sequencer with a sense network model.
// Assumes the package counts; normal mode lies beyond the run length.
`timescale 1ns/10ps
`define CHK(nm, ex, got) \
	n_checks++; \
	if ((got) !== (ex)) begin \
		failures++; \
		$display("[ERR] %s expected %0d seen %0d", nm, ex, got); \
	end
module tb_top
	import pwm_ctrl_pkg::*;
;
	logic              ref_clk_i = 1'b0;
	logic              rst_i;
	logic              supply_ok_i;
	logic              restart_i;
	logic              burst_mode_i;
	comp_flags_s       comp;
	logic              gate_o;
	logic              sink_en_o;
	logic [STEP_W-1:0] ramp_up_level_o;
	logic              soft_done_o;
	logic              blank_o;
	logic              burst_limit_en_o;
	logic              slope_comp_en_o;
	logic [3:0][9:0]   dly;
	logic              spike;
	int                failures = 0;
	int                n_checks = 0;

	always #20 ref_clk_i = ~ref_clk_i;

	pwm_softstart_limiter pwm_softstart_limiter_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
		.supply_ok_i(supply_ok_i), .restart_i(restart_i), .burst_mode_i(burst_mode_i),
		.comp_i(comp), .gate_o(gate_o), .sink_en_o(sink_en_o),
		.ramp_up_level_o(ramp_up_level_o), .soft_done_o(soft_done_o), .blank_o(blank_o),
		.burst_limit_en_o(burst_limit_en_o), .slope_comp_en_o(slope_comp_en_o));
	sense_network_model sense_network_model_inst (.ref_clk_i(ref_clk_i), .gate_i(gate_o),
		.dly_i(dly), .spike_i(spike), .comp_o(comp));

	// ****************************************
	// Helpers
	// ****************************************
	task complete_run;
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Bounded wait for a level on a design output, counting cycles
	task automatic wait_for(input string nm, ref logic sig, input logic lvl, output int n);
		n = 0;
		while (sig !== lvl) begin
			@(negedge ref_clk_i);
			n++;
			if (n > 20000) begin
				failures++;
				$display("[ERR] %s expected %0d seen timeout", nm, lvl);
				complete_run();
			end
		end
	endtask

	// Measures one gate pulse: on-time, period to the next pulse and blanked cycles
	// Level is taken on the last high cycle: the step in force then sets the ceiling
	task automatic pulse(output int on, output int per, output int blk, output int lvl);
		int off;
		wait_for("gate_rise", gate_o, 1'b1, off);
		on = 0;
		blk = 0;
		lvl = 0;
		while (gate_o === 1'b1 && on < 1000) begin
			blk += (blank_o === 1'b1);
			lvl = int'(ramp_up_level_o);
			on++;
			@(negedge ref_clk_i);
		end
		wait_for("gate_rise", gate_o, 1'b1, off);
		per = on + off;
	endtask

	// ****************************************
	// Main sequence
	// ****************************************
	initial begin
		int n, t, on, per, blk, kind, d, cap, lo, hi, last, highs, lvl;
		logic acc;
		logic [3:0][9:0] dv;
		void'($urandom(97));
		rst_i = 1'b1;
		supply_ok_i = 1'b0;
		restart_i = 1'b0;
		burst_mode_i = 1'b0;
		spike = 1'b0;
		dly = '1;
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		highs = 0;
		repeat (50) begin
			@(negedge ref_clk_i);
			highs += (gate_o === 1'b1);
		end
		`CHK("gate_in_lockout", 0, highs)
		`CHK("sink_in_lockout", 1'b0, sink_en_o)
		@(posedge ref_clk_i);
		supply_ok_i <= 1'b1;
		wait_for("sink_en", sink_en_o, 1'b1, n);
		`CHK("start_latency_ok", 1'b1, n <= 6)
		`CHK("first_step", 5'h00, ramp_up_level_o)
		`CHK("slope_en", 1'b1, slope_comp_en_o)
		`CHK("done_low", 1'b0, soft_done_o)
		t = 0;
		highs = 0;
		while (ramp_up_level_o === 5'h00 && t < 9000) begin
			@(negedge ref_clk_i);
			highs += (gate_o === 1'b1);
			t++;
		end
		`CHK("no_pulse_step0", 0, highs)
		`CHK("step_time_ok", 1'b1, t >= STEP_CYCLES - 2 && t <= STEP_CYCLES + 2)
		last = 1;
		while (ramp_up_level_o < 5'h06) begin
			wait_for("gate_low", gate_o, 1'b0, n);
			@(posedge ref_clk_i);
			kind = $urandom % 4;
			d = 8 + $urandom % 40;
			burst_mode_i <= 1'($urandom % 2);
			spike <= 1'($urandom % 2);
			dv = '1;
			dv[3 - kind] = d[9:0];
			dly <= dv;
			@(negedge ref_clk_i);
			acc = (kind != 3) || burst_mode_i;
			pulse(on, per, blk, lvl);
			cap = PERIOD_NOM * lvl * DMAX_NUM / (SOFT_STEPS * DMAX_DEN);
			lo = acc && d + 1 < cap - 1 ? d + 1 : cap - 1;
			hi = acc && d + 5 < cap + 1 ? d + 5 : cap + 1;
			`CHK("on_time_ok", 1'b1, on >= lo && on <= hi)
			`CHK("period", PERIOD_NOM, per)
			`CHK("burst_en", burst_mode_i, burst_limit_en_o)
			if (on > BLANK_NORM_CYC) begin
				`CHK("blank_len", burst_mode_i ? BLANK_BURST_CYC : BLANK_NORM_CYC, blk)
			end
			`CHK("step_by_one", 1'b1, ramp_up_level_o - last <= 1)
			last = ramp_up_level_o;
		end
		@(posedge ref_clk_i);
		restart_i <= 1'b1;
		repeat (4) @(posedge ref_clk_i);
		restart_i <= 1'b0;
		repeat (6) @(negedge ref_clk_i);
		`CHK("restart_level", 5'h00, ramp_up_level_o)
		`CHK("restart_sink", 1'b1, sink_en_o)
		wait_for("gate_rise", gate_o, 1'b1, n);
		@(posedge ref_clk_i);
		supply_ok_i <= 1'b0;
		repeat (4) @(negedge ref_clk_i);
		`CHK("gate_off_uv", 1'b0, gate_o)
		`CHK("level_cleared", 5'h00, ramp_up_level_o)
		`CHK("sink_off_uv", 1'b0, sink_en_o)
		@(posedge ref_clk_i);
		supply_ok_i <= 1'b1;
		wait_for("sink_en", sink_en_o, 1'b1, n);
		`CHK("new_start_level", 5'h00, ramp_up_level_o)
		complete_run();
	end

	// Cuts a hang short
	initial begin
		repeat (100000) @(posedge ref_clk_i);
		failures++;
		$display("[ERR] run_length expected 100000 seen exceeded");
		complete_run();
	end
endmodule
